//--- inc/qei_pkg.sv
package qei_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL    = 8'h10;
   localparam logic [7:0] IDX_PIN_STATE  = 8'h11;
   localparam logic [7:0] IDX_POSITION   = 8'h14;
   localparam logic [7:0] IDX_LATCHED    = 8'h18;
   localparam logic [7:0] IDX_DIV_COUNT  = 8'h1c;
   localparam logic [7:0] IDX_DIV_LIMIT  = 8'h1d;
   localparam logic [7:0] IDX_DEV_LIMIT  = 8'h1e;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h21;
   localparam logic [7:0] IDX_RAMP_LATCH = 8'h40;
   localparam logic [7:0] IDX_RAMP_HELD  = 8'h50;

   // control field positions
   localparam int CTL_INDEX_POLARITY        = 0;
   localparam int CTL_CLEAR_ON_INDEX        = 1;
   localparam int CTL_LATCH_ON_INDEX        = 2;
   localparam int CTL_LATCH_NOW             = 3;
   localparam int CTL_LOAD_FROM_RAMP        = 4;
   localparam int CTL_LATCH_WITH_SNAPSHOT   = 5;
   localparam int CTL_COUNT_DIRECTION_SELECT = 6;

   // interrupt status / mask field positions
   localparam int IRQ_DEVIATION = 0;
   localparam int IRQ_INDEX     = 1;
   localparam int IRQ_LATCH     = 2;

   // widths
   localparam int CTL_W  = 7;
   localparam int POS_W  = 24;
   localparam int DIV_W  = 8;
   localparam int DEV_W  = 12;
   localparam int IRQ_W  = 3;
   localparam int ADDR_W = 10;

   // reset values
   localparam logic [CTL_W-1:0] CONTROL_RESET   = 7'h00;
   localparam logic [POS_W-1:0] POSITION_RESET  = 24'h000000;
   localparam logic [DIV_W-1:0] DIV_LIMIT_RESET = 8'h00;
   localparam logic [DEV_W-1:0] DEV_LIMIT_RESET = 12'h000;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET  = 3'h0;

   // avalon-mm request from the master
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic              read;
      logic              write;
      logic [31:0]       writedata;
      logic [3:0]        byteenable;
   } avl_req_t;

   // encoder pins; bit order equals the pin state register
   typedef struct packed {
      logic quad_phase_a;
      logic quad_phase_b;
      logic index_pulse;
   } enc_pins_t;

endpackage

//--- src/quad_decoder.sv
`timescale 1ns/1ps
module quad_decoder (
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire qei_pkg::enc_pins_t pins_raw,
   output qei_pkg::enc_pins_t      pins_level,
   output logic                    step_valid,
   output logic                    step_a_lead
);
   import qei_pkg::*;

   typedef struct packed {
      enc_pins_t s1;
      enc_pins_t s2;
      enc_pins_t s3;
      enc_pins_t level;
      logic      valid;
      logic      a_lead;
   } dec_state_t;

   dec_state_t state_reg;
   dec_state_t state_next;

   // three-stage sync, then accept a level once stages two and three agree
   always_comb begin
      logic [2:0] cand;
      logic [2:0] s2v;
      logic [2:0] s3v;
      cand = state_reg.level;
      s2v = state_reg.s2;
      s3v = state_reg.s3;
      state_next = state_reg;
      state_next.s1 = pins_raw;
      state_next.s2 = state_reg.s1;
      state_next.s3 = state_reg.s2;
      state_next.valid = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (s2v[i] == s3v[i]) begin
            cand[i] = s3v[i];
         end
      end
      // one phase moving is a step; both moving is a skipped state, not counted
      if ((cand[2] ^ state_reg.level.quad_phase_a) != (cand[1] ^ state_reg.level.quad_phase_b)) begin
         state_next.valid = 1'b1;
         state_next.a_lead = cand[2] ^ state_reg.level.quad_phase_b;
      end
      state_next.level = cand;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pins_level  = state_reg.level;
   assign step_valid  = state_reg.valid;
   assign step_a_lead = state_reg.a_lead;
endmodule

//--- src/quadrature_encoder_interface.sv
`timescale 1ns/1ps
// Function
// - index input counts as active high with control bit 0 set, active low when clear.
// - with control bit 1 set, the next active index clears the position counter.
// - with control bit 2 set, the next active index copies the position into the latch.
// - writing control bit 3 as one latches the position at once and the bit self-clears.
// - writing control bit 4 as one loads the position from the ramp position, self-clearing.
// - with control bit 5 set, the position is latched with every ramp register-copy strobe.
// - control bit 6 picks direction: one means A leading B counts up, zero means B leading.
// - the pin state register reads index in bit 0, phase B in bit 1 and phase A in bit 2.
// - the 24-bit position counter is readable and writable by software.
// - the 24-bit latched position register is read-only and holds position snapshots.
// - an 8-bit readable, writable pre-divider counter counts encoder signal changes.
// - an 8-bit pre-divider limit sets the counter maximum, for ratios one to 256.
// - an interrupt is raised when abs(position - ramp position) exceeds a 12-bit limit; its status bit holds until cleared.
// - decoded position steps are also given out as a pulse with a direction output.
// - the register-copy strobe from the ramp latch write or a command snapshots ramp values.
module quadrature_encoder_interface (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire qei_pkg::avl_req_t  avl_req,
   output logic [31:0]             avl_readdata,
   output logic                    avl_waitrequest,
   input  wire qei_pkg::enc_pins_t enc_pins,
   input  wire logic [23:0]        ramp_position,
   input  wire logic               ramp_cmd_copy,
   output logic                    ramp_copy_strobe,
   output logic                    step_pulse,
   output logic                    step_dir,
   output logic                    deviation_exceeded,
   output logic                    irq
);
   import qei_pkg::*;

   typedef struct packed {
      logic [CTL_W-1:0] ctrl;
      logic [POS_W-1:0] position;
      logic [POS_W-1:0] latched_position_value;
      logic [DIV_W-1:0] div_count;
      logic [DIV_W-1:0] div_limit;
      logic [DEV_W-1:0] dev_limit;
      logic [POS_W-1:0] ramp_held;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic             index_prev;
      logic             dev_over;
      logic             irq;
      logic             waitreq;
      logic [31:0]      rdata;
      logic             step_pulse;
      logic             step_dir;
      logic             copy_strobe;
   } qei_state_t;

   qei_state_t state_reg;
   qei_state_t state_next;

   enc_pins_t  pins_level;
   logic       step_valid;
   logic       step_a_lead;

   // pin synchroniser and quadrature decode
   quad_decoder u_decoder (
      .core_clk    (core_clk),
      .rst         (rst),
      .pins_raw    (enc_pins),
      .pins_level  (pins_level),
      .step_valid  (step_valid),
      .step_a_lead (step_a_lead)
   );

   // merge written bytes over the old word
   function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction

   // bus decode
   logic [7:0]  reg_idx;
   logic        wr_go;
   logic [31:0] wmerge;
   logic [31:0] rd_mux;

   assign reg_idx = avl_req.address[ADDR_W-1:2];
   // a write lands on the edge where the master sees waitrequest low
   assign wr_go   = avl_req.write && !state_reg.waitreq;

   // read data selection; unmapped indices read zero
   // the ramp latch address is write-only and reads zero too
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (reg_idx)
         IDX_CONTROL:    rd_mux = {25'h0, state_reg.ctrl};
         IDX_PIN_STATE:  rd_mux = {29'h0, pins_level};
         IDX_POSITION:   rd_mux = {8'h00, state_reg.position};
         IDX_LATCHED:    rd_mux = {8'h00, state_reg.latched_position_value};
         IDX_DIV_COUNT:  rd_mux = {24'h0, state_reg.div_count};
         IDX_DIV_LIMIT:  rd_mux = {24'h0, state_reg.div_limit};
         IDX_DEV_LIMIT:  rd_mux = {20'h0, state_reg.dev_limit};
         IDX_IRQ_STATUS: rd_mux = {29'h0, state_reg.irq_status};
         IDX_IRQ_MASK:   rd_mux = {29'h0, state_reg.irq_mask};
         IDX_RAMP_HELD:  rd_mux = {8'h00, state_reg.ramp_held};
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   // per-register byte merge for software writes
   always_comb begin
      wmerge = 32'h0000_0000;
      case (reg_idx)
         IDX_CONTROL:   wmerge = be_merge({25'h0, state_reg.ctrl},
                                          avl_req.writedata, avl_req.byteenable);
         IDX_POSITION:  wmerge = be_merge({8'h00, state_reg.position},
                                          avl_req.writedata, avl_req.byteenable);
         IDX_DIV_COUNT: wmerge = be_merge({24'h0, state_reg.div_count},
                                          avl_req.writedata, avl_req.byteenable);
         IDX_DIV_LIMIT: wmerge = be_merge({24'h0, state_reg.div_limit},
                                          avl_req.writedata, avl_req.byteenable);
         IDX_DEV_LIMIT: wmerge = be_merge({20'h0, state_reg.dev_limit},
                                          avl_req.writedata, avl_req.byteenable);
         IDX_IRQ_MASK:  wmerge = be_merge({29'h0, state_reg.irq_mask},
                                          avl_req.writedata, avl_req.byteenable);
         default:       wmerge = avl_req.writedata & {{8{avl_req.byteenable[3]}},
                                                      {8{avl_req.byteenable[2]}},
                                                      {8{avl_req.byteenable[1]}},
                                                      {8{avl_req.byteenable[0]}}};
      endcase
   end

   // index edge: active level depends on the polarity bit
   // a polarity write with the pin already at the new active level is an edge too
   logic index_active;
   logic index_edge;

   assign index_active = (pins_level.index_pulse == state_reg.ctrl[CTL_INDEX_POLARITY]);
   assign index_edge   = index_active && !state_reg.index_prev;

   // one write strobe per register, each tied to a completed transfer
   logic wr_ctrl;
   logic wr_pos;
   logic wr_div_cnt;
   logic wr_div_lim;
   logic wr_dev_lim;
   logic wr_mask;
   logic wr_status;
   logic latch_now;
   logic load_from_ramp_position;
   logic copy_now;

   assign wr_ctrl    = wr_go && (reg_idx == IDX_CONTROL);
   assign wr_pos     = wr_go && (reg_idx == IDX_POSITION);
   assign wr_div_cnt = wr_go && (reg_idx == IDX_DIV_COUNT);
   assign wr_div_lim = wr_go && (reg_idx == IDX_DIV_LIMIT);
   assign wr_dev_lim = wr_go && (reg_idx == IDX_DEV_LIMIT);
   assign wr_mask    = wr_go && (reg_idx == IDX_IRQ_MASK);
   assign wr_status  = wr_go && (reg_idx == IDX_IRQ_STATUS);

   // one-shot commands from a control write
   assign latch_now = wr_ctrl && wmerge[CTL_LATCH_NOW];
   assign load_from_ramp_position = wr_ctrl && wmerge[CTL_LOAD_FROM_RAMP];
   // copy strobe from the latch address write or a command with the copy flag
   assign copy_now = ramp_cmd_copy || (wr_go && (reg_idx == IDX_RAMP_LATCH));

   // pre-divider wrap and count direction
   // limit 0 wraps on every step, 255 on every 256th
   logic div_wrap;
   logic count_up;

   assign div_wrap = step_valid && (state_reg.div_count >= state_reg.div_limit);
   // a_lead matches select bit: up; otherwise down
   assign count_up = (step_a_lead == state_reg.ctrl[CTL_COUNT_DIRECTION_SELECT]);

   // deviation between encoder and ramp position; both wrap at 24 bits,
   // so the wrapped difference is a signed distance with bit 23 as sign
   logic [POS_W-1:0] diff_full;
   logic [POS_W-1:0] diff_abs;
   logic             dev_over;

   assign diff_full = state_reg.position - ramp_position;

   // magnitude of the signed distance
   always_comb begin
      if (diff_full[POS_W-1]) begin
         diff_abs = POS_W'(0) - diff_full;
      end else begin
         diff_abs = diff_full;
      end
   end

   // a distance equal to the limit is still in bounds
   assign dev_over  = (diff_abs > {12'h000, state_reg.dev_limit});

   // main next-state logic
   always_comb begin
      logic latch_evt;
      logic index_hit;
      latch_evt = 1'b0;
      index_hit = 1'b0;
      state_next = state_reg;
      state_next.index_prev  = index_active;
      state_next.step_pulse  = 1'b0;
      state_next.copy_strobe = copy_now;
      state_next.dev_over    = dev_over;

      // bus handshake: waitrequest drops for one cycle after a request
      // read data is taken with the request and holds until the next request, read or write
      if ((avl_req.read || avl_req.write) && state_reg.waitreq) begin
         state_next.waitreq = 1'b0;
         state_next.rdata   = rd_mux;
      end else begin
         state_next.waitreq = 1'b1;
      end

      // quadrature steps through the pre-divider
      if (step_valid) begin
         if (div_wrap) begin
            state_next.div_count = 8'h00;
            state_next.position = count_up ? state_reg.position + 24'h000001
                                            : state_reg.position - 24'h000001;
            state_next.step_pulse = 1'b1;
            state_next.step_dir   = count_up;
         end else begin
            state_next.div_count = state_reg.div_count + 8'h01;
         end
      end

      // index events; each armed function fires once and disarms
      if (index_edge) begin
         index_hit = 1'b1;
         if (state_reg.ctrl[CTL_CLEAR_ON_INDEX]) begin
            state_next.position = POSITION_RESET;
            state_next.ctrl[CTL_CLEAR_ON_INDEX] = 1'b0;
         end
         if (state_reg.ctrl[CTL_LATCH_ON_INDEX]) begin
            latch_evt = 1'b1;
            state_next.ctrl[CTL_LATCH_ON_INDEX] = 1'b0;
         end
      end

      // ramp snapshot strobe
      if (copy_now) begin
         state_next.ramp_held = ramp_position;
         if (state_reg.ctrl[CTL_LATCH_WITH_SNAPSHOT]) begin
            latch_evt = 1'b1;
         end
      end

      // software writes; they win over the counting logic above
      if (wr_ctrl) begin
         state_next.ctrl = wmerge[CTL_W-1:0];
         // both one-shot bits never stay stored, so they read back zero
         state_next.ctrl[CTL_LATCH_NOW] = 1'b0;
         state_next.ctrl[CTL_LOAD_FROM_RAMP] = 1'b0;
      end
      if (latch_now) begin
         latch_evt = 1'b1;
      end

      // position: a ramp load overrides a same-cycle software write
      if (wr_pos) begin
         state_next.position = wmerge[POS_W-1:0];
      end
      if (load_from_ramp_position) begin
         state_next.position = ramp_position;
      end

      // a count write beats a same-cycle divider step
      if (wr_div_cnt) begin
         state_next.div_count = wmerge[DIV_W-1:0];
      end
      if (wr_div_lim) begin
         state_next.div_limit = wmerge[DIV_W-1:0];
      end

      // limits and mask act from the next cycle on
      if (wr_dev_lim) begin
         state_next.dev_limit = wmerge[DEV_W-1:0];
      end
      if (wr_mask) begin
         state_next.irq_mask = wmerge[IRQ_W-1:0];
      end

      // latch takes the counter value before this cycle's update
      if (latch_evt) begin
         state_next.latched_position_value = state_reg.position;
      end

      // sticky status: write one clears, a same-cycle event wins
      if (wr_status) begin
         state_next.irq_status = state_reg.irq_status & ~wmerge[IRQ_W-1:0];
      end
      if (dev_over) begin
         state_next.irq_status[IRQ_DEVIATION] = 1'b1;
      end
      if (index_hit) begin
         state_next.irq_status[IRQ_INDEX] = 1'b1;
      end
      if (latch_evt) begin
         state_next.irq_status[IRQ_LATCH] = 1'b1;
      end

      // level interrupt, one cycle behind the status bits
      state_next.irq = |(state_reg.irq_status & state_reg.irq_mask);
   end

   // state register; waitrequest rests high so no answer is given unasked
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.ctrl <= CONTROL_RESET;
         state_reg.position <= POSITION_RESET;
         state_reg.div_limit <= DIV_LIMIT_RESET;
         state_reg.dev_limit <= DEV_LIMIT_RESET;
         state_reg.irq_mask <= IRQ_MASK_RESET;
         state_reg.waitreq <= 1'b1;
         state_reg.index_prev <= 1'b1; // an index already active at reset is no edge
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign avl_readdata       = state_reg.rdata;
   assign avl_waitrequest    = state_reg.waitreq;

   // motion side outputs
   assign ramp_copy_strobe   = state_reg.copy_strobe;
   assign step_pulse         = state_reg.step_pulse;
   assign step_dir           = state_reg.step_dir;
   assign deviation_exceeded = state_reg.dev_over;
   assign irq                = state_reg.irq;
endmodule

//--- verification/encoder_iface_sva.sv
`timescale 1ns/1ps
module encoder_iface_sva (
   input wire logic              core_clk,
   input wire logic              rst,
   input wire qei_pkg::avl_req_t avl_req,
   input wire logic [31:0]       avl_readdata,
   input wire logic              avl_waitrequest,
   input wire logic              ramp_cmd_copy,
   input wire logic              ramp_copy_strobe,
   input wire logic              step_pulse,
   input wire logic              step_dir,
   input wire logic              irq
);
   import qei_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [7:0] idx;
   logic       seen;
   logic       rd_seen;
   logic       latch_wr;
   // request qualifiers seen from the bus side only
   assign idx = avl_req.address[9:2];
   assign seen = (avl_req.read | avl_req.write) & avl_waitrequest;
   assign rd_seen = seen & avl_req.read;
   assign latch_wr = avl_req.write & ~avl_waitrequest & (idx == IDX_RAMP_LATCH);

   property p_answer; seen |=> !avl_waitrequest; endproperty
   a_answer: assert property (p_answer) else $error("request not answered next cycle");
   property p_one; !avl_waitrequest |=> avl_waitrequest; endproperty
   a_one: assert property (p_one) else $error("waitrequest low too long");
   property p_idle; !avl_req.read && !avl_req.write && avl_waitrequest |=> avl_waitrequest;
   endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   property p_copy; ramp_cmd_copy |=> ramp_copy_strobe; endproperty
   a_copy: assert property (p_copy) else $error("copy command gave no strobe");
   property p_src;
      ramp_copy_strobe |-> $past(ramp_cmd_copy) || $past(latch_wr);
   endproperty
   a_src: assert property (p_src) else $error("copy strobe without cause");
   property p_pulse; step_pulse |=> !step_pulse; endproperty
   a_pulse: assert property (p_pulse) else $error("step pulse too long");
   property p_ctl; rd_seen && idx == IDX_CONTROL |=> avl_readdata[31:7] == 0 &&
      avl_readdata[4:3] == 2'h0; endproperty
   a_ctl: assert property (p_ctl) else $error("control self-clear bits read set");
   property p_pins; rd_seen && idx == IDX_PIN_STATE |=> avl_readdata[31:3] == 0; endproperty
   a_pins: assert property (p_pins) else $error("pin state upper bits set");
   property p_pos; rd_seen && (idx == IDX_POSITION || idx == IDX_LATCHED)
      |=> avl_readdata[31:24] == 8'h00; endproperty
   a_pos: assert property (p_pos) else $error("position wider than 24 bits");
   property p_unmap; rd_seen && idx == 8'h0f |=> avl_readdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   c_strobe: cover property (ramp_copy_strobe);
   c_up: cover property (step_pulse && step_dir);
   c_down: cover property (step_pulse && !step_dir);
   c_irq: cover property ($rose(irq));
endmodule

//--- verification/quad_encoder_model.sv
`timescale 1ns/1ps
module quad_encoder_model (
   input  wire logic          core_clk,
   input  wire logic          rst,
   input  wire logic          move,
   input  wire logic          fwd,
   input  wire logic          jump,
   input  wire logic          index_lvl,
   output qei_pkg::enc_pins_t pins
);
   import qei_pkg::*;
   logic [1:0] phase_reg;
   // phase ring 00,10,11,01 has a leading a going forward
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phase_reg <= 2'h0;
      end else if (jump) begin
         phase_reg <= phase_reg + 2'h2; // both phases flip together, a faulty encoder
      end else if (move) begin
         phase_reg <= fwd ? phase_reg + 2'h1 : phase_reg - 2'h1;
      end
   end
   // push-pull encoder outputs, always driven; one assignment for the whole struct
   assign pins = '{quad_phase_a: phase_reg[1] ^ phase_reg[0], quad_phase_b: phase_reg[1],
                   index_pulse: index_lvl};
endmodule

//--- verification/quadrature_encoder_interface_bench.sv
`timescale 1ns/1ps
module quadrature_encoder_interface_bench;
   import qei_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   avl_req_t    avl_req = '{10'h000, 1'b0, 1'b0, 32'h0, 4'hf};
   logic [31:0] avl_readdata;
   logic        avl_waitrequest;
   enc_pins_t   enc_pins;
   logic [23:0] ramp_position = 24'h000000;
   logic        ramp_cmd_copy = 1'b0;
   logic        ramp_copy_strobe, step_pulse, step_dir, deviation_exceeded, irq;
   logic        move = 1'b0, fwd = 1'b1, jump = 1'b0, index_lvl = 1'b0;
   logic [31:0] rd;
   int          fails = 0, checks = 0, pulses = 0;

   always #5 core_clk = ~core_clk;
   // count steps given out at the pulse output
   always @(posedge core_clk) if (step_pulse === 1'b1) pulses <= pulses + 1;

   quadrature_encoder_interface i_dut (.core_clk, .rst, .avl_req, .avl_readdata,
      .avl_waitrequest, .enc_pins, .ramp_position, .ramp_cmd_copy, .ramp_copy_strobe,
      .step_pulse, .step_dir, .deviation_exceeded, .irq);
   quad_encoder_model i_enc (.core_clk, .rst, .move, .fwd, .jump, .index_lvl,
      .pins(enc_pins));

   task automatic wrap_up();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon transfer; waitrequest and read data are sampled at rising edges
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avl_req.address <= {idx, 2'b00};
      avl_req.read <= ~wr;
      avl_req.write <= wr;
      avl_req.writedata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (avl_waitrequest !== 1'b0 && n < 20);
      if (avl_waitrequest !== 1'b0) begin
         fails++;
         wrap_up();
      end
      rd = avl_readdata;
      avl_req.read <= 1'b0;
      avl_req.write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(idx, 1'b1, d);
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      bus(idx, 1'b0, 32'h0);
      chk(rd, exp);
   endtask

   // lets synchroniser, divider and irq pipeline settle
   task automatic settle();
      repeat (8) @(negedge core_clk);
   endtask

   // spacing well above the two cycles the decoder needs between edges of one phase
   task automatic steps(input int n, input logic dir);
      repeat (n) begin
         @(posedge core_clk);
         fwd <= dir;
         move <= 1'b1;
         @(posedge core_clk);
         move <= 1'b0;
         settle();
      end
   endtask

   task automatic t_regs();
      rdchk(IDX_CONTROL, 32'h0);
      rdchk(IDX_DIV_LIMIT, 32'h0);
      wr(IDX_POSITION, 32'hffabcdef);
      rdchk(IDX_POSITION, 32'h00abcdef);
      wr(IDX_LATCHED, 32'h00123456);
      rdchk(IDX_LATCHED, 32'h0);
      wr(IDX_DEV_LIMIT, 32'hffffffff);
      rdchk(IDX_DEV_LIMIT, 32'h00000fff);
      wr(IDX_DIV_COUNT, 32'h000001a5);
      rdchk(IDX_DIV_COUNT, 32'h000000a5);
      wr(8'h0f, 32'hffffffff);
      rdchk(8'h0f, 32'h0);
      wr(IDX_CONTROL, 32'hffffff67);
      rdchk(IDX_CONTROL, 32'h00000067);
   endtask

   task automatic t_dir();
      int p0;
      wr(IDX_CONTROL, 32'h40);
      wr(IDX_DIV_LIMIT, 32'h0);
      wr(IDX_DIV_COUNT, 32'h0);
      wr(IDX_POSITION, 32'h0);
      p0 = pulses;
      steps(3, 1'b1);
      rdchk(IDX_POSITION, 32'h3);
      chk(step_dir, 1'b1);
      steps(5, 1'b0);
      rdchk(IDX_POSITION, 32'h00fffffe);
      chk(step_dir, 1'b0);
      chk(32'(pulses - p0), 32'h8);
      wr(IDX_CONTROL, 32'h0);
      steps(2, 1'b1);
      rdchk(IDX_POSITION, 32'h00fffffc);
   endtask

   task automatic t_div();
      wr(IDX_CONTROL, 32'h40);
      wr(IDX_POSITION, 32'h0);
      wr(IDX_DIV_LIMIT, 32'h2);
      steps(7, 1'b1);
      rdchk(IDX_POSITION, 32'h2);
      rdchk(IDX_DIV_COUNT, 32'h1);
      wr(IDX_DIV_LIMIT, 32'hff);
      wr(IDX_DIV_COUNT, 32'hfe);
      steps(1, 1'b1);
      rdchk(IDX_POSITION, 32'h2);
      steps(1, 1'b1);
      rdchk(IDX_POSITION, 32'h3);
      rdchk(IDX_DIV_COUNT, 32'h0);
      wr(IDX_DIV_LIMIT, 32'h0);
      @(posedge core_clk);
      jump <= 1'b1;
      @(posedge core_clk);
      jump <= 1'b0;
      settle();
      rdchk(IDX_POSITION, 32'h3);
      steps(1, 1'b1);
      rdchk(IDX_POSITION, 32'h4);
      index_lvl <= 1'b1;
      settle();
      rdchk(IDX_PIN_STATE, {29'h0, enc_pins});
   endtask

   task automatic t_load_index();
      ramp_position <= 24'h123456;
      wr(IDX_CONTROL, 32'h10);
      rdchk(IDX_POSITION, 32'h00123456);
      rdchk(IDX_CONTROL, 32'h0);
      wr(IDX_POSITION, 32'h00000abc);
      wr(IDX_CONTROL, 32'h08);
      rdchk(IDX_LATCHED, 32'h00000abc);
      wr(IDX_POSITION, 32'h5);
      wr(IDX_CONTROL, 32'h01);
      wr(IDX_CONTROL, 32'h05);
      index_lvl <= 1'b0;
      settle();
      rdchk(IDX_LATCHED, 32'h00000abc);
      index_lvl <= 1'b1;
      settle();
      rdchk(IDX_LATCHED, 32'h5);
      rdchk(IDX_CONTROL, 32'h01);
      wr(IDX_CONTROL, 32'h00);
      wr(IDX_CONTROL, 32'h02);
      rdchk(IDX_POSITION, 32'h5);
      index_lvl <= 1'b0;
      settle();
      rdchk(IDX_POSITION, 32'h0);
      rdchk(IDX_PIN_STATE, {29'h0, enc_pins});
   endtask

   task automatic t_snap();
      wr(IDX_CONTROL, 32'h20);
      wr(IDX_POSITION, 32'h77);
      ramp_position <= 24'h00beef;
      ramp_cmd_copy <= 1'b1;
      @(posedge core_clk);
      ramp_cmd_copy <= 1'b0;
      rdchk(IDX_LATCHED, 32'h77);
      rdchk(IDX_RAMP_HELD, 32'h0000beef);
      wr(IDX_POSITION, 32'h99);
      ramp_position <= 24'h00cafe;
      wr(IDX_RAMP_LATCH, 32'h0);
      rdchk(IDX_LATCHED, 32'h99);
      rdchk(IDX_RAMP_HELD, 32'h0000cafe);
   endtask

   // deviation is exceeded only above the limit, ramp ahead of encoder, then encoder ahead of ramp
   task automatic t_dev();
      wr(IDX_CONTROL, 32'h0);
      ramp_position <= 24'h000008;
      wr(IDX_DEV_LIMIT, 32'h3);
      wr(IDX_POSITION, 32'h5);
      wr(IDX_IRQ_STATUS, 32'h7);
      rdchk(IDX_IRQ_STATUS, 32'h0);
      wr(IDX_IRQ_MASK, 32'h1);
      settle();
      chk(irq, 1'b0);
      wr(IDX_POSITION, 32'h4);
      settle();
      chk(deviation_exceeded, 1'b1);
      chk(irq, 1'b1);
      rdchk(IDX_IRQ_STATUS, 32'h1);
      wr(IDX_IRQ_MASK, 32'h0);
      settle();
      chk(irq, 1'b0);
      wr(IDX_POSITION, 32'h5);
      wr(IDX_IRQ_STATUS, 32'h1);
      wr(IDX_IRQ_MASK, 32'h1);
      settle();
      chk(deviation_exceeded, 1'b0);
      chk(irq, 1'b0);
      wr(IDX_POSITION, 32'hc); // encoder ahead of the ramp by four
      settle();
      chk(deviation_exceeded, 1'b1);
   endtask

   // reset, then the scenarios in turn
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      t_regs();
      t_dir();
      t_div();
      t_load_index();
      t_snap();
      t_dev();
      wrap_up();
   end
endmodule

bind quadrature_encoder_interface encoder_iface_sva i_sva (.core_clk, .rst, .avl_req,
   .avl_readdata, .avl_waitrequest, .ramp_cmd_copy, .ramp_copy_strobe, .step_pulse,
   .step_dir, .irq);
